// ==== src/apmm_pkg.sv ====
package apmm_pkg;

    // Clock and documented times
    localparam int CLK_MHZ       = 100;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int CONV_TIME_NS  = 4600;
    localparam int WAKE_TIME_NS  = 5000;
    localparam int CAL_TIME_MS   = 32;

    // Cycle counts, derived from the times above except INIT_CYC
    localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC = WAKE_TIME_NS / CLK_PERIOD_NS;
    localparam int CAL_CYC  = CAL_TIME_MS * 1000 * CLK_MHZ;
    localparam int INIT_CYC = 4;

    localparam int TMR_W  = 23;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

    // Control register bit positions
    localparam int CTRL_LO_BIT   = 0;
    localparam int CTRL_HI_BIT   = 1;
    localparam int CTRL_CONV_BIT = 2;
    localparam int CTRL_CAL_BIT  = 3;

    // Power select codes
    localparam logic [1:0] SEL_PIN     = 2'h0;
    localparam logic [1:0] SEL_NORMAL  = 2'h1;
    localparam logic [1:0] SEL_FULL_PD = 2'h2;
    localparam logic [1:0] SEL_PART_PD = 2'h3;
    localparam logic [1:0] SEL_RESET   = 2'h0;

    typedef enum logic [2:0] {
        ST_INIT    = 3'h0,
        ST_CAL     = 3'h1,
        ST_ACTIVE  = 3'h2,
        ST_WAKE    = 3'h3,
        ST_CONV    = 3'h4,
        ST_FULL_PD = 3'h5,
        ST_PART_PD = 3'h6
    } apmm_state_e;

    typedef struct packed {
        logic track;
        logic ref_on;
        logic core_on;
        logic busy;
    } apmm_pwr_s;

    typedef struct packed {
        logic [22:0] pad;
        logic [1:0]  sel;
        logic        sleep_lvl;
        logic        ref_on;
        logic        core_on;
        logic        busy;
        apmm_state_e state;
    } apmm_status_s;

endpackage : apmm_pkg

// ==== src/apmm_sync.sv ====
`timescale 1ns/10ps
module apmm_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= RST;
            q    <= RST;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule : apmm_sync

// ==== src/apmm_timer.sv ====
`timescale 1ns/10ps
module apmm_timer #(
    parameter int             W   = 23,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              zero
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb begin
        if (load) begin
            next_cnt = load_val;
        end else if (cnt != '0) begin
            next_cnt = cnt - W'(1);
        end else begin
            next_cnt = cnt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= RST;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign zero = (cnt == '0);
endmodule : apmm_timer

// ==== src/apmm_top.sv ====
`timescale 1ns/10ps
module apmm_top
    import apmm_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sleep_n,
    input  wire logic        calib_n,
    input  wire logic        conversion_trigger_n,
    output apmm_pkg::apmm_pwr_s pwr
);
    import apmm_pkg::*;

    // Pin synchronisers: sleep, calibration, trigger (idle high)
    logic [2:0] pins_s;
    logic       sleep_s;
    logic       calib_s;
    logic       trig_s;

    apmm_sync #(.W(3), .RST(3'h7)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({sleep_n, calib_n, conversion_trigger_n}),
        .q       (pins_s)
    );
    assign sleep_s = pins_s[2];
    assign calib_s = pins_s[1];
    assign trig_s  = pins_s[0];

    // Bus slave state
    logic              dp_wr;
    logic [ADDR_W-1:0] dp_addr;
    logic              next_dp_wr;
    logic [ADDR_W-1:0] next_dp_addr;
    logic [31:0]       next_hrdata;
    logic              ap_valid;

    // Control state
    logic [1:0]  pwr_sel;
    logic        part_req;
    logic        conv_req;
    logic        cal_req;
    logic        start_pend;
    logic        trig_d;
    logic [1:0]  next_pwr_sel;
    logic        next_part_req;
    logic        next_conv_req;
    logic        next_cal_req;
    logic        next_start_pend;
    logic        ctrl_wr;

    apmm_state_e state;
    apmm_state_e next_state;
    apmm_pwr_s   next_pwr;
    apmm_status_s status;

    logic             tmr_zero;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic             auto_mode;
    logic             normal_mode;
    logic             trig_fall;
    logic             trig_rise;
    logic             conv_go;

    apmm_timer #(.W(TMR_W), .RST(TMR_W'(INIT_CYC))) u_timer (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .zero     (tmr_zero)
    );

    // AHB-Lite slave: zero wait states, always OKAY
    always_comb begin
        ap_valid     = hsel && hready && htrans[1];
        next_dp_wr   = ap_valid && hwrite;
        next_dp_addr = ap_valid ? haddr[ADDR_W-1:0] : dp_addr;
        next_hrdata  = '0;
        if (ap_valid && !hwrite) begin
            if (haddr[ADDR_W-1:0] == CTRL_OFS) begin
                next_hrdata = {30'h0, pwr_sel};
            end else if (haddr[ADDR_W-1:0] == STAT_OFS) begin
                next_hrdata = status;
            end else begin
                next_hrdata = '0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr     <= 1'b0;
            dp_addr   <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp_wr     <= next_dp_wr;
            dp_addr   <= next_dp_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb begin
        status           = '0;
        status.sel       = pwr_sel;
        status.sleep_lvl = sleep_s;
        status.ref_on    = pwr.ref_on;
        status.core_on   = pwr.core_on;
        status.busy      = pwr.busy;
        status.state     = state;
    end

    // Control register and request flags
    always_comb begin
        ctrl_wr         = dp_wr && (dp_addr == CTRL_OFS);
        next_pwr_sel    = pwr_sel;
        next_conv_req   = 1'b0;
        next_cal_req    = 1'b0;
        next_part_req   = part_req;
        next_start_pend = start_pend;
        if (ctrl_wr) begin
            next_pwr_sel  = {hwdata[CTRL_HI_BIT], hwdata[CTRL_LO_BIT]};
            next_conv_req = hwdata[CTRL_CONV_BIT];
            next_cal_req  = hwdata[CTRL_CAL_BIT];
        end
        // Partial power-down armed by an explicit write, dropped by calibration; set wins
        if (state == ST_CAL || pwr_sel != SEL_PART_PD) begin
            next_part_req = 1'b0;
        end
        if (ctrl_wr && next_pwr_sel == SEL_PART_PD) begin
            next_part_req = 1'b1;
        end
        if (state == ST_CONV || state == ST_FULL_PD || state == ST_PART_PD) begin
            next_start_pend = 1'b0;
        end
        if (state == ST_WAKE && trig_rise) begin
            next_start_pend = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_sel    <= SEL_RESET;
            conv_req   <= 1'b0;
            cal_req    <= 1'b0;
            part_req   <= 1'b0;
            start_pend <= 1'b0;
            trig_d     <= 1'b1;
        end else begin
            pwr_sel    <= next_pwr_sel;
            conv_req   <= next_conv_req;
            cal_req    <= next_cal_req;
            part_req   <= next_part_req;
            start_pend <= next_start_pend;
            trig_d     <= trig_s;
        end
    end

    // Power state machine
    always_comb begin
        auto_mode   = (pwr_sel == SEL_PIN) && !sleep_s;
        normal_mode = (pwr_sel == SEL_NORMAL) || ((pwr_sel == SEL_PIN) && sleep_s);
        trig_fall   = trig_d && !trig_s;
        trig_rise   = !trig_d && trig_s;
        conv_go     = trig_rise || conv_req || start_pend;
        next_state  = state;
        case (state)
            ST_INIT: begin
                if (tmr_zero) begin
                    next_state = calib_s ? ST_ACTIVE : ST_CAL;
                end
            end
            ST_CAL: begin
                // Sleep pin and select bits are not looked at here
                if (tmr_zero) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (cal_req) begin
                    next_state = ST_CAL;
                end else if (conv_go) begin
                    next_state = ST_CONV;
                end else if (pwr_sel == SEL_FULL_PD) begin
                    next_state = ST_FULL_PD;
                end else if (pwr_sel == SEL_PART_PD && part_req && trig_s) begin
                    next_state = ST_PART_PD;
                end else if (auto_mode && trig_s) begin
                    next_state = ST_FULL_PD;
                end
            end
            ST_CONV: begin
                if (tmr_zero) begin
                    if (auto_mode || pwr_sel == SEL_FULL_PD) begin
                        next_state = ST_FULL_PD;
                    end else begin
                        next_state = ST_ACTIVE;
                    end
                end
            end
            ST_FULL_PD: begin
                if (normal_mode || (auto_mode && trig_fall)) begin
                    next_state = ST_WAKE;
                end else if (pwr_sel == SEL_PART_PD && part_req) begin
                    next_state = ST_PART_PD;
                end
            end
            ST_PART_PD: begin
                if (normal_mode) begin
                    next_state = ST_WAKE;
                end else if (pwr_sel == SEL_FULL_PD) begin
                    next_state = ST_FULL_PD;
                end else if (pwr_sel == SEL_PART_PD && trig_fall) begin
                    next_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (tmr_zero) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_INIT;
            end
        endcase

        tmr_load = (next_state != state) &&
                   (next_state == ST_CAL || next_state == ST_CONV || next_state == ST_WAKE);
        case (next_state)
            ST_CAL:  tmr_val = TMR_W'(CAL_CYCLES - 1);
            ST_CONV: tmr_val = TMR_W'(CONV_CYC - 1);
            ST_WAKE: tmr_val = TMR_W'(WAKE_CYC - 1);
            default: tmr_val = '0;
        endcase

        next_pwr.busy    = (next_state == ST_CAL) || (next_state == ST_CONV);
        next_pwr.core_on = (next_state != ST_FULL_PD) && (next_state != ST_PART_PD);
        next_pwr.ref_on  = (next_state != ST_FULL_PD);
        next_pwr.track   = (next_state == ST_ACTIVE);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_INIT;
            pwr   <= '{track: 1'b0, ref_on: 1'b1, core_on: 1'b1, busy: 1'b0};
        end else begin
            state <= next_state;
            pwr   <= next_pwr;
        end
    end

    // Assertion helpers: length of the previous stay in a state
    localparam int CONV_LEN = CONV_CYC;
    localparam int WAKE_LEN = WAKE_CYC;
    apmm_state_e      prev_state;
    logic [TMR_W-1:0] run_len;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_state <= ST_INIT;
            run_len    <= '0;
        end else begin
            prev_state <= state;
            run_len    <= (next_state != state) ? TMR_W'(1) : run_len + TMR_W'(1);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_full_pd_off: assert property (state == ST_FULL_PD |-> !pwr.core_on && !pwr.ref_on)
        else $error("full power-down leaves circuitry on");
    a_part_pd_ref: assert property (state == ST_PART_PD |-> !pwr.core_on && pwr.ref_on)
        else $error("partial power-down reference or core wrong");
    a_cal_holds_on: assert property (state == ST_CAL && !tmr_zero |=> state == ST_CAL)
        else $error("calibration left early");
    a_mode01_no_pd: assert property (pwr_sel == SEL_NORMAL && state == ST_ACTIVE && !cal_req
        |=> pwr.core_on)
        else $error("normal select powered down");
    a_sleep_high_on: assert property (pwr_sel == SEL_PIN && sleep_s && state == ST_ACTIVE
        |=> pwr.core_on)
        else $error("sleep high powered down");
    a_conv_length: assert property (prev_state == ST_CONV && state != ST_CONV
        |-> $past(run_len) == TMR_W'(CONV_LEN))
        else $error("conversion length wrong");
    a_wake_length: assert property (prev_state == ST_WAKE && state != ST_WAKE
        |-> $past(run_len) == TMR_W'(WAKE_LEN) && state == ST_ACTIVE)
        else $error("wake time wrong");
    a_auto_pd_end: assert property ($fell(pwr.busy) && $past(state) == ST_CONV
        && $past(auto_mode) |-> state == ST_FULL_PD)
        else $error("no power-down after conversion");
    a_trig_wakes: assert property (state == ST_FULL_PD && auto_mode && trig_fall
        |=> state == ST_WAKE ##1 pwr.core_on)
        else $error("trigger fall did not wake");
    a_cal_skip: assert property (state == ST_INIT && tmr_zero && calib_s
        |=> state == ST_ACTIVE)
        else $error("calibration not skipped");
    a_track_busy: assert property ($fell(pwr.busy) && state == ST_ACTIVE |-> pwr.track)
        else $error("no tracking after busy fall");

endmodule : apmm_top

// ==== tb/apmm_host_model.sv ====
`timescale 1ns/10ps
module apmm_host_model
    import apmm_pkg::*;
(
    input  wire logic hclk,
    output logic      sleep_n,
    output logic      calib_n,
    output logic      conversion_trigger_n
);
    int low_cyc;

    initial begin
        sleep_n              = 1'b1;
        calib_n              = 1'b1;
        conversion_trigger_n = 1'b1;
        low_cyc              = 0;
    end

    always @(posedge hclk) begin
        low_cyc <= conversion_trigger_n ? 0 : low_cyc + 1;
    end

    // Levels held until changed; high sleep for software-only control
    task automatic set_pins(input logic s, input logic c);
        @(posedge hclk);
        sleep_n <= s;
        calib_n <= c;
    endtask : set_pins

    // Low phase never shorter than the wake time, so power-up completes first
    task automatic pulse(input int extra);
        @(posedge hclk);
        conversion_trigger_n <= 1'b0;
        @(posedge hclk);
        while (low_cyc < WAKE_CYC + extra) begin
            @(posedge hclk);
        end
        conversion_trigger_n <= 1'b1;
    endtask : pulse
endmodule : apmm_host_model

// ==== tb/apmm_tb_top.sv ====
`timescale 1ns/10ps
module apmm_tb_top;
    import apmm_pkg::*;
    localparam int CAL_N = 50;
    // Power-up time before a self-calibration when autocalibration is skipped
    localparam int PWR_UP_CYC = 300_000 / CLK_PERIOD_NS;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sleep_n, calib_n, trig_n;
    apmm_pwr_s   pwr;
    int          n_errors, checked;

    assign hready = hreadyout;

    apmm_top #(.CAL_CYCLES(CAL_N)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_n(sleep_n),
        .calib_n(calib_n), .conversion_trigger_n(trig_n), .pwr(pwr));

    apmm_host_model i_host (
        .hclk(hclk), .sleep_n(sleep_n), .calib_n(calib_n), .conversion_trigger_n(trig_n));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic fail(input string msg);
        n_errors++;
        $display("Error at %0t: %s", $time, msg);
    endtask : fail

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) fail(msg);
    endtask : check_word

    task automatic check_pwr(input logic [3:0] exp, input string msg);
        checked++;
        if (pwr !== exp) fail(msg);
    endtask : check_pwr

    task automatic check_count(input int got, input int lo, input int hi, input string msg);
        checked++;
        if (got < lo || got > hi) fail(msg);
    endtask : check_count

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin
            fail("bus timeout");
            tally_and_finish();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check_word(r, exp, msg);
        check_word({31'h0, hresp}, 32'h0, "response not OKAY");
    endtask : rd_chk

    task automatic wait_state(input apmm_state_e st, input int lim, input string msg);
        logic [31:0] d;
        int          n;
        n = 0;
        do begin
            bus(1'b0, STAT_OFS, 32'h0, d);
            n++;
        end while (d[2:0] !== st && n < lim);
        check_word({29'h0, d[2:0]}, {29'h0, st}, msg);
    endtask : wait_state

    task automatic cnt_until(input int b, input logic v, input int lim, output int n);
        n = 0;
        while (pwr[b] !== v && n < lim) begin
            @(posedge hclk);
            n++;
        end
    endtask : cnt_until

    task automatic run_conv(input bit wake);
        int n1, n2;
        fork
            i_host.pulse(100);
            begin
                if (wake) begin
                    cnt_until(1, 1'b1, 30, n1);
                    cnt_until(3, 1'b1, WAKE_CYC + 20, n2);
                    check_count(n1 + n2, WAKE_CYC, WAKE_CYC + 10, "wake time");
                end
                cnt_until(0, 1'b1, 2 * WAKE_CYC, n1);
                cnt_until(0, 1'b0, CONV_CYC + 10, n2);
                check_count(n2, CONV_CYC, CONV_CYC, "conversion length");
            end
        join
    endtask : run_conv

    task automatic do_reset(input logic s, input logic c);
        i_host.set_pins(s, c);
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    initial begin
        #1_000_000;
        fail("run timeout");
        tally_and_finish();
    end

    initial begin
        int n;
        hresetn  = 1'b0;
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = 3'h2;
        hwdata   = 32'h0;
        checked  = 0;
        n_errors = 0;
        do_reset(1'b1, 1'b1);
        wait_state(ST_ACTIVE, 8, "calibration not skipped");
        rd_chk(CTRL_OFS, 32'h0, "control reset value");
        check_pwr(4'he, "normal levels");
        repeat (PWR_UP_CYC) @(posedge hclk);
        wr(CTRL_OFS, 32'h8);
        wait_state(ST_CAL, 3, "self-calibration start");
        $display("Test skip-calibration done");
        do_reset(1'b0, 1'b0);
        wait_state(ST_CAL, 8, "calibration not running");
        check_pwr(4'h7, "calibration levels");
        wait_state(ST_FULL_PD, 40, "no power-down after calibration");
        check_pwr(4'h0, "power-down levels");
        $display("Test power-on calibration done");
        run_conv(1'b1);
        check_pwr(4'h0, "no power-down at busy fall");
        $display("Test between-conversions done");
        i_host.set_pins(1'b1, 1'b0);
        wait_state(ST_ACTIVE, 300, "sleep high not normal");
        run_conv(1'b0);
        check_pwr(4'he, "not tracking after busy");
        $display("Test sleep-high conversion done");
        wr(CTRL_OFS, 32'h1);
        i_host.set_pins(1'b0, 1'b0);
        run_conv(1'b0);
        repeat (20) @(posedge hclk);
        wait_state(ST_ACTIVE, 1, "select 01 follows sleep");
        rd_chk(CTRL_OFS, 32'h1, "control readback");
        wr(CTRL_OFS, 32'h5);
        cnt_until(0, 1'b1, 10, n);
        check_count(n, 0, 9, "software start");
        cnt_until(0, 1'b0, CONV_CYC + 10, n);
        check_count(n, CONV_CYC, CONV_CYC, "software conversion length");
        wait_state(ST_ACTIVE, 2, "not back to normal");
        $display("Test software select done");
        wr(CTRL_OFS, 32'h2);
        wait_state(ST_FULL_PD, 5, "select 10 state");
        check_pwr(4'h0, "select 10 levels");
        wr(CTRL_OFS, 32'h3);
        wait_state(ST_PART_PD, 5, "select 11 state");
        check_pwr(4'h4, "select 11 levels");
        $display("Test power-down codes done");
        wr(CTRL_OFS, 32'h1);
        wait_state(ST_ACTIVE, 300, "wake from partial");
        wr(CTRL_OFS, 32'hb);
        wait_state(ST_CAL, 3, "software calibration");
        wait_state(ST_ACTIVE, 40, "calibration end state");
        repeat (20) @(posedge hclk);
        wait_state(ST_ACTIVE, 1, "partial power-down after calibration");
        wr(CTRL_OFS, 32'h3);
        wait_state(ST_PART_PD, 5, "explicit partial power-down");
        run_conv(1'b1);
        wait_state(ST_PART_PD, 5, "no partial power-down after conversion");
        $display("Test calibration sequence done");
        wr(8'h10, 32'hffffffff);
        rd_chk(8'h10, 32'h0, "unmapped read");
        rd_chk(CTRL_OFS, 32'h3, "unmapped write leaked");
        $display("Test unmapped access done");
        tally_and_finish();
    end
endmodule : apmm_tb_top
